// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic i_sys_clk,
  input wire logic i_battery_low_oe,
  input wire logic i_battery_low_out_n,
  input wire logic i_system_reset_n,
  output wire logic o_bl_line,
  output logic o_data_suspect
);
  assign o_bl_line = i_battery_low_oe ? i_battery_low_out_n : 1'b1;
  always @(posedge i_sys_clk) begin
    if (!i_system_reset_n) begin
      o_data_suspect <= !o_bl_line;
    end
  end
endmodule : host_model

// ### bench/supervisor_checker.sv
`timescale 1ns/1ps
module supervisor_checker
  import supervisor_pkg::*;
#(
  parameter longint unsigned RELEASE_CYCLES_P = RELEASE_DELAY_CYCLES,
  parameter longint unsigned RECOVERY_CYCLES_P = RECOVERY_CYCLES,
  parameter longint unsigned CHECK_CYCLES_P = CHECK_INTERVAL_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reset_request_in_n,
  input wire logic i_supply_ok,
  input wire logic i_battery_ok,
  input wire logic i_supply_fail_sense_in,
  input wire logic o_system_reset_n,
  input wire logic o_battery_low_out_n,
  input wire logic o_battery_low_oe,
  input wire logic o_supply_fail_flag_out_n
);
  logic [7:0] run_reg;
  logic req_reg;
  // Length of the latest low run on the request input, saturating.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      run_reg <= 8'h00;
      req_reg <= 1'b1;
    end else begin
      req_reg <= i_reset_request_in_n;
      if (!i_reset_request_in_n) begin
        if (req_reg) begin
          run_reg <= 8'h01;
        end else if (run_reg != 8'hFF) begin
          run_reg <= run_reg + 8'h01;
        end
      end
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_short_ignored: assert property (i_supply_ok[*6] ##0
    $fell(o_system_reset_n) |-> run_reg >= 8'h07)
    else $error("short pulse reset");
  a_long_taken: assert property ((!i_reset_request_in_n)[*8] |->
    ##[0:6] !o_system_reset_n) else $error("request not taken");
  a_hold_low: assert property (
    !i_reset_request_in_n && !o_system_reset_n
    |=> (!o_system_reset_n)[*8]) else $error("reset released early");
  a_reset_rise: assert property (
    $rose(o_system_reset_n) |-> i_supply_ok
    && $past(i_supply_ok, 8) && i_reset_request_in_n) else $error("bad rise");
  a_backup_flag: assert property ((!i_supply_ok)[*5] |->
    !o_supply_fail_flag_out_n && !o_system_reset_n) else $error("backup flag");
  a_recover_high: assert property ($rose(i_supply_ok) |-> ##5
    (o_supply_fail_flag_out_n || !i_supply_ok)[*8]) else $error("not forced");
  a_follow_sense: assert property (
    (o_system_reset_n && i_supply_ok && $stable(i_supply_fail_sense_in))[*4]
    |-> o_supply_fail_flag_out_n == i_supply_fail_sense_in)
    else $error("flag not following sense");
  a_od_data: assert property (o_battery_low_out_n == 1'b0)
    else $error("open drain data high");
  a_oe_check_only: assert property ($changed(o_battery_low_oe) |->
    $past(i_supply_ok, 3)) else $error("battery flag changed in backup");
  c_req_reset: cover property ((!i_reset_request_in_n)[*8] ##6 !o_system_reset_n);
  c_supply_back: cover property ($rose(i_supply_ok));
  c_oe_rise: cover property ($rose(o_battery_low_oe));
  c_sense_low: cover property (o_system_reset_n && !o_supply_fail_flag_out_n);
endmodule : supervisor_checker
bind supervisor_reset_battery_monitor supervisor_checker #(
  .RELEASE_CYCLES_P(RELEASE_CYCLES_P), .RECOVERY_CYCLES_P(RECOVERY_CYCLES_P),
  .CHECK_CYCLES_P(CHECK_CYCLES_P)) chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_reset_request_in_n(i_reset_request_in_n), .i_supply_ok(i_supply_ok),
  .i_battery_ok(i_battery_ok), .i_supply_fail_sense_in(i_supply_fail_sense_in),
  .o_system_reset_n(o_system_reset_n), .o_battery_low_oe(o_battery_low_oe),
  .o_battery_low_out_n(o_battery_low_out_n),
  .o_supply_fail_flag_out_n(o_supply_fail_flag_out_n));

// ### bench/supervisor_reset_battery_monitor_tb.sv
`timescale 1ns/1ps
module supervisor_reset_battery_monitor_tb;
  import supervisor_pkg::*;
  localparam int REL = 50;
  localparam int REC = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_n = 1'b1;
  logic sup = 1'b1;
  logic bat = 1'b0;
  logic sense = 1'b1;
  logic rn, bln, oe, pfn;
  wire bl_line;
  wire suspect;
  int fails = 0;
  int tests_run = 0;
  int seed = 10;
  int cycles = 0;
  int r;
  int n;
  always #4 clk = ~clk;
  supervisor_reset_battery_monitor #(.RELEASE_CYCLES_P(64'd50),
    .RECOVERY_CYCLES_P(64'd40), .CHECK_CYCLES_P(64'd300)) uut (
    .i_sys_clk(clk), .i_rst(rst), .i_reset_request_in_n(req_n),
    .i_supply_ok(sup), .i_battery_ok(bat), .i_supply_fail_sense_in(sense),
    .o_system_reset_n(rn), .o_battery_low_out_n(bln),
    .o_battery_low_oe(oe), .o_supply_fail_flag_out_n(pfn));
  host_model host (.i_sys_clk(clk), .i_battery_low_oe(oe),
    .i_battery_low_out_n(bln), .i_system_reset_n(rn),
    .o_bl_line(bl_line), .o_data_suspect(suspect));
  task end_sim;
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // High when a low request of n cycles is shorter than REJECT_PULSE_NS.
  function automatic logic pulse_ignored(input int n);
    pulse_ignored = (n * int'(CLK_PERIOD_NS)) < int'(REJECT_PULSE_NS);
  endfunction : pulse_ignored
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task pulse(input int n);
    @(posedge clk);
    req_n <= 1'b0;
    repeat (n) @(posedge clk);
    req_n <= 1'b1;
    #1;
  endtask : pulse
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(20);
    chk(rn, 1'b0);
    chk(pfn, 1'b1);
    chk(oe, 1'b1);
    chk(bl_line, 1'b0);
    chk(suspect, 1'b1);
    cyc(REC);
    chk(rn, 1'b1);
    @(posedge clk);
    bat <= 1'b1;
    cyc(100);
    chk(oe, 1'b1);
    cyc(300);
    chk(oe, 1'b0);
    chk(bl_line, 1'b1);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      @(posedge clk);
      sense <= r[0];
      cyc(6);
      chk(pfn, r[0]);
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      n = (i == 0) ? 6 : 1 + int'(r[2:0]) % 6;
      pulse(n);
      cyc(15);
      chk(rn, pulse_ignored(n));
    end
    pulse(15);
    cyc(REL + 30);
    chk(rn, 1'b1);
    for (int i = 0; i < 2; i++) begin
      pulse(MIN_REQUEST_CYCLES);
      chk(rn, pulse_ignored(MIN_REQUEST_CYCLES));
      if (i == 0) cyc(20);
    end
    cyc(REL - 5);
    chk(rn, 1'b0);
    cyc(15);
    chk(rn, 1'b1);
    @(posedge clk);
    sup <= 1'b0;
    bat <= 1'b0;
    sense <= 1'b1;
    cyc(6);
    chk(pfn, 1'b0);
    chk(rn, 1'b0);
    cyc(400);
    chk(oe, 1'b0);
    @(posedge clk);
    sup <= 1'b1;
    sense <= 1'b0;
    req_n <= 1'b0;
    cyc(10);
    chk(pfn, 1'b1);
    chk(oe, 1'b1);
    cyc(REC);
    chk(pfn, 1'b0);
    chk(rn, 1'b0);
    @(posedge clk);
    req_n <= 1'b1;
    cyc(REL - 5);
    chk(rn, 1'b0);
    cyc(15);
    chk(rn, 1'b1);
    chk(suspect, 1'b1);
    end_sim();
  end
endmodule : supervisor_reset_battery_monitor_tb

// ### rtl/pulse_filter.sv
`timescale 1ns/1ps
module pulse_filter
  import supervisor_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_level_n,
  output logic o_accept
);
  logic [FILTER_W-1:0] cnt_reg;
  logic [FILTER_W-1:0] cnt_next;
  logic acc_reg;
  logic acc_next;
  localparam logic [FILTER_W-1:0] LIMIT = FILTER_W'(REJECT_CYCLES);

  always_comb begin
    cnt_next = cnt_reg;
    acc_next = 1'b0;
    if (i_level_n) begin
      cnt_next = '0;
    end else if (cnt_reg != LIMIT) begin
      cnt_next = cnt_reg + FILTER_W'(1);
    end else begin
      acc_next = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      acc_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
    end
  end

  assign o_accept = acc_reg;
endmodule : pulse_filter

// ### rtl/supervisor_reset_battery_monitor.sv
`timescale 1ns/1ps
// Operation
// - Low request pulses shorter than 50 ns cause no reset.
// - Reset output stays low 40 to 200 ms after the request returns high.
// - The battery is checked at power-up and every 24 hours or more.
// - A failing check asserts the active-low battery-low output.
// - Battery-low stays until a later check passes.
// - Checks run only while the main supply is nominal.
// - Battery-low is open drain: drive low or release.
// - With supply valid and comparator on, fail flag follows the sense.
// - In back-up the comparator is off and the fail flag is held low.
// - On supply return the fail flag is forced high for the recovery time.
// - After recovery the comparator is on and the flag follows the sense.
// - A requested reset lasts the release delay, not the recovery time of a power-cycle reset.
module supervisor_reset_battery_monitor
  import supervisor_pkg::*;
#(
  parameter longint unsigned RELEASE_CYCLES_P = RELEASE_DELAY_CYCLES,
  parameter longint unsigned RECOVERY_CYCLES_P = RECOVERY_CYCLES,
  parameter longint unsigned CHECK_CYCLES_P = CHECK_INTERVAL_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reset_request_in_n,
  input wire logic i_supply_ok,
  input wire logic i_battery_ok,
  input wire logic i_supply_fail_sense_in,
  output logic o_system_reset_n,
  output logic o_battery_low_out_n,
  output logic o_battery_low_oe,
  output logic o_supply_fail_flag_out_n
);
  typedef enum logic [3:0] {
    ST_BACKUP = 4'b0001,
    ST_RECOVER = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HOLD = 4'b1000
  } mode_e;

  function automatic logic [TIMER_W-1:0] bump(
    input logic [TIMER_W-1:0] v
  );
    bump = v + TIMER_W'(1);
  endfunction : bump

  logic req_s1_reg;
  logic req_s2_reg;
  logic sup_s1_reg;
  logic sup_s2_reg;
  logic bat_s1_reg;
  logic bat_s2_reg;
  logic sen_s1_reg;
  logic sen_s2_reg;
  logic accept;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      req_s1_reg <= 1'b1;
      req_s2_reg <= 1'b1;
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
      bat_s1_reg <= 1'b1;
      bat_s2_reg <= 1'b1;
      sen_s1_reg <= 1'b1;
      sen_s2_reg <= 1'b1;
    end else begin
      req_s1_reg <= i_reset_request_in_n;
      req_s2_reg <= req_s1_reg;
      sup_s1_reg <= i_supply_ok;
      sup_s2_reg <= sup_s1_reg;
      bat_s1_reg <= i_battery_ok;
      bat_s2_reg <= bat_s1_reg;
      sen_s1_reg <= i_supply_fail_sense_in;
      sen_s2_reg <= sen_s1_reg;
    end
  end

  pulse_filter u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_level_n(req_s2_reg),
    .o_accept(accept)
  );

  mode_e mode_reg;
  mode_e mode_next;
  logic [TIMER_W-1:0] tmr_reg;
  logic [TIMER_W-1:0] tmr_next;
  logic rst_n_reg;
  logic rst_n_next;
  logic [TIMER_W-1:0] chk_reg;
  logic [TIMER_W-1:0] chk_next;
  logic bl_reg;
  logic bl_next;
  logic pf_n_reg;
  logic pf_n_next;
  logic start_check;

  localparam logic [TIMER_W-1:0] REL_LAST = TIMER_W'(RELEASE_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] REC_LAST = TIMER_W'(RECOVERY_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] CHK_LAST = TIMER_W'(CHECK_CYCLES_P - 1);

  // Mode, stretch timer and system reset.
  always_comb begin
    mode_next = mode_reg;
    tmr_next = tmr_reg;
    rst_n_next = rst_n_reg;
    if (!sup_s2_reg) begin
      mode_next = ST_BACKUP;
      tmr_next = '0;
      rst_n_next = 1'b0;
    end else begin
      unique case (mode_reg)
        ST_BACKUP: begin
          mode_next = ST_RECOVER;
          tmr_next = '0;
        end
        ST_RECOVER: begin
          rst_n_next = 1'b0;
          tmr_next = bump(tmr_reg);
          if (tmr_reg == REC_LAST) begin
            tmr_next = '0;
            if (accept) begin
              mode_next = ST_HOLD;
            end else begin
              mode_next = ST_RUN;
              rst_n_next = 1'b1;
            end
          end
        end
        ST_RUN: begin
          rst_n_next = 1'b1;
          if (accept) begin
            mode_next = ST_HOLD;
            rst_n_next = 1'b0;
            tmr_next = '0;
          end
        end
        ST_HOLD: begin
          rst_n_next = 1'b0;
          if (!req_s2_reg) begin
            tmr_next = '0;
          end else begin
            tmr_next = bump(tmr_reg);
            if (tmr_reg == REL_LAST) begin
              mode_next = ST_RUN;
              rst_n_next = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= ST_BACKUP;
      tmr_reg <= '0;
      rst_n_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      tmr_reg <= tmr_next;
      rst_n_reg <= rst_n_next;
    end
  end

  // Battery check scheduler and battery-low flag.
  always_comb begin
    chk_next = chk_reg;
    bl_next = bl_reg;
    start_check = 1'b0;
    if (!sup_s2_reg) begin
      chk_next = '0;
    end else if (mode_reg == ST_BACKUP) begin
      start_check = 1'b1;
    end else begin
      chk_next = bump(chk_reg);
      if (chk_reg == CHK_LAST) begin
        chk_next = '0;
        start_check = 1'b1;
      end
    end
    if (start_check) begin
      bl_next = !bat_s2_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_reg <= '0;
      bl_reg <= 1'b0;
    end else begin
      chk_reg <= chk_next;
      bl_reg <= bl_next;
    end
  end

  // Supply-fail flag.
  always_comb begin
    pf_n_next = pf_n_reg;
    if (!sup_s2_reg) begin
      pf_n_next = 1'b0;
    end else if (mode_reg == ST_BACKUP || mode_reg == ST_RECOVER) begin
      pf_n_next = 1'b1;
    end else begin
      pf_n_next = sen_s2_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pf_n_reg <= 1'b0;
    end else begin
      pf_n_reg <= pf_n_next;
    end
  end

  assign o_system_reset_n = rst_n_reg;
  assign o_battery_low_out_n = 1'b0;
  assign o_battery_low_oe = bl_reg;
  assign o_supply_fail_flag_out_n = pf_n_reg;
endmodule : supervisor_reset_battery_monitor

// ### shared/supervisor_pkg.sv
package supervisor_pkg;
  localparam int unsigned CLK_FREQ_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Glitch rejection limit in ns; requests shorter than this are ignored.
  localparam int unsigned REJECT_PULSE_NS = 50;
  // Guaranteed accepted request width in ns.
  localparam int unsigned MIN_REQUEST_PULSE_NS = 200;
  // Reset stretch after request release, in ms, inside the 40..200 window.
  localparam int unsigned RELEASE_DELAY_MIN_MS = 40;
  localparam int unsigned RELEASE_DELAY_MAX_MS = 200;
  localparam int unsigned RELEASE_DELAY_MS = 100;
  // Recovery period of the supply-fail comparator, in ms.
  localparam int unsigned RECOVERY_PERIOD_MS = 200;
  // Battery check interval in hours.
  localparam int unsigned CHECK_INTERVAL_H = 24;
  // Filter length: accept after more than the rejection limit (round up).
  localparam int unsigned REJECT_CYCLES =
    (REJECT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_REQUEST_CYCLES =
    (MIN_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned RELEASE_DELAY_CYCLES =
    longint'(RELEASE_DELAY_MS) * (CLK_FREQ_HZ / 1000);
  localparam longint unsigned RECOVERY_CYCLES =
    longint'(RECOVERY_PERIOD_MS) * (CLK_FREQ_HZ / 1000);
  localparam longint unsigned CHECK_INTERVAL_CYCLES =
    longint'(CHECK_INTERVAL_H) * 64'd3600 * longint'(CLK_FREQ_HZ);
  localparam int unsigned FILTER_W = 4;
  localparam int unsigned TIMER_W = 48;
endpackage : supervisor_pkg
